// File: dir_reg_bank.sv
// Small memory of port direction registers, written whole bytes only.
`timescale 1ns/10ps
module dir_reg_bank (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic we_i,
    input wire logic [gpio_dir_pkg::DIR_IDX_W-1:0] idx_i,
    input wire logic [gpio_dir_pkg::DATA_W-1:0] wdata_i,
    output logic [gpio_dir_pkg::NUM_DIR*gpio_dir_pkg::DATA_W-1:0] dir_o
);
    import gpio_dir_pkg::*;

    logic [DATA_W-1:0] mem_q [NUM_DIR];

    ////////////////////////////////////////////////////////////////////////
    genvar g;
    for (g = 0; g < NUM_DIR; g++) begin : g_reg
        always_ff @(posedge clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
                mem_q[g] <= DIR_RESET;
            end else if (ce_i && we_i && idx_i == DIR_IDX_W'(g)) begin
                mem_q[g] <= wdata_i;
            end
        end
        assign dir_o[g*DATA_W +: DATA_W] = mem_q[g];
    end

endmodule

// File: gpio_dir_pkg.sv
// Package with register map, field layout and reset values of the port block.
package gpio_dir_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int NUM_DIR = 6;
    localparam int DIR_IDX_W = 3;

    // Register offsets, one byte register per address.
    localparam logic [3:0] OFF_PORT1_DIR = 4'h0;
    localparam logic [3:0] OFF_PORT2_DIR = 4'h1;
    localparam logic [3:0] OFF_PORT3_DIR = 4'h2;
    localparam logic [3:0] OFF_PIN_LEVELS4 = 4'h3;
    localparam logic [3:0] OFF_PORT5_DIR = 4'h4;
    localparam logic [3:0] OFF_PORTA_DIR = 4'h5;
    localparam logic [3:0] OFF_PORTB_DIR = 4'h6;

    // Field layout of the port 4 pin-level register.
    localparam int PIN4_LSB = 0;
    localparam int PIN4_MSB = 3;
    localparam int PIN4_W = 4;
    localparam logic [3:0] PIN4_RSVD_VAL = 4'h0;

    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] RD_NONE = 8'h00;
    // Value returned when a write-only register is read; any value is legal.
    localparam logic [7:0] WO_READ_VAL = 8'h00;

    localparam logic [2:0] IDX_NONE = 3'h7;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

endpackage

// File: gpio_dir_regs.sv
// Port direction registers and port 4 pin-level register behind a byte bus.
//
// Operation
// - Direction register reads return no stored value.
// - Direction registers take whole-byte writes only.
// - Reset clears all direction bits to zero.
// - Port 4 register shows live pins, read-only.
// - Port 4 bits 7 to 4 are reserved.
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
module gpio_dir_regs (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic [gpio_dir_pkg::ADDR_W-1:0] addr_i,
    input wire logic [gpio_dir_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [gpio_dir_pkg::PIN4_W-1:0] pin_levels_bank4_pins_i,
    output logic [gpio_dir_pkg::DATA_W-1:0] rdata_o,
    output logic [gpio_dir_pkg::DATA_W-1:0] port1_oe_o,
    output logic [gpio_dir_pkg::DATA_W-1:0] port2_oe_o,
    output logic [gpio_dir_pkg::DATA_W-1:0] port3_oe_o,
    output logic [gpio_dir_pkg::DATA_W-1:0] port5_oe_o,
    output logic [gpio_dir_pkg::DATA_W-1:0] porta_oe_o,
    output logic [gpio_dir_pkg::DATA_W-1:0] portb_oe_o
);
    import gpio_dir_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Address decode.

    function automatic logic [DIR_IDX_W-1:0] dir_index(
        input logic [ADDR_W-1:0] a
    );
        logic [DIR_IDX_W-1:0] r;
        r = IDX_NONE;
        unique case (a)
            OFF_PORT1_DIR: r = 3'h0;
            OFF_PORT2_DIR: r = 3'h1;
            OFF_PORT3_DIR: r = 3'h2;
            OFF_PORT5_DIR: r = 3'h3;
            OFF_PORTA_DIR: r = 3'h4;
            OFF_PORTB_DIR: r = 3'h5;
            default: r = IDX_NONE;
        endcase
        return r;
    endfunction

    reg_req_s req;
    logic [DIR_IDX_W-1:0] wr_idx;
    logic is_dir;
    logic is_pin4;
    logic dir_we;
    logic [NUM_DIR*DATA_W-1:0] dir_all;
    logic [DATA_W-1:0] rdata_d;
    logic [DATA_W-1:0] rdata_q;
    logic [PIN4_W-1:0] pin_meta_q;
    logic [PIN4_W-1:0] pin_sync_q;
    logic [NUM_DIR*DATA_W-1:0] oe_q;

    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
    assign wr_idx = dir_index(req.addr);
    assign is_dir = (wr_idx != IDX_NONE);
    assign is_pin4 = (req.addr == OFF_PIN_LEVELS4);
    assign dir_we = req.wr && is_dir;

    ////////////////////////////////////////////////////////////////////////
    // Direction storage.

    dir_reg_bank u_bank (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .we_i(dir_we),
        .idx_i(wr_idx),
        .wdata_i(req.wdata),
        .dir_o(dir_all)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pin sampling; the pins are asynchronous to the bus clock.

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
        end else if (ce_i) begin
            pin_meta_q <= pin_levels_bank4_pins_i;
            pin_sync_q <= pin_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path.

    assign rdata_d = !req.rd ? RD_NONE :
        is_pin4 ? {PIN4_RSVD_VAL, pin_sync_q} :
        is_dir ? WO_READ_VAL : RD_NONE;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_q <= RD_NONE;
        end else if (ce_i) begin
            rdata_q <= rdata_d;
        end
    end

    // Output enables are registered once more so that every port leaves
    // straight from a flip-flop; this costs one cycle of pin latency.
    // bit drives pin
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            oe_q <= '0;
        end else if (ce_i) begin
            oe_q <= dir_all;
        end
    end

    assign rdata_o = rdata_q;
    assign port1_oe_o = oe_q[0*DATA_W +: DATA_W];
    assign port2_oe_o = oe_q[1*DATA_W +: DATA_W];
    assign port3_oe_o = oe_q[2*DATA_W +: DATA_W];
    assign port5_oe_o = oe_q[3*DATA_W +: DATA_W];
    assign porta_oe_o = oe_q[4*DATA_W +: DATA_W];
    assign portb_oe_o = oe_q[5*DATA_W +: DATA_W];

endmodule

// File: gpio_dir_regs_bench.sv
// Self-checking bench for the port direction block.
`timescale 1ns/10ps
module gpio_dir_regs_bench;
    import gpio_dir_pkg::*;
    logic clk_i = 0;
    logic resetn_i = 1'b1;
    logic ce = 1'b1;
    logic [3:0] pin_levels_bank4_pins_i = '0;
    logic [7:0] d, p1, p2, p3, p5, pa, pb;
    logic [47:0] ex;
    reg_req_s q = '0;
    int errors = 0;
    int comparisons = 0;
    int cyc = 0;
    logic [3:0] offs[6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6};
    logic [7:0] vals[6] = '{8'ha5, 8'h5a, 8'hff, 8'h01, 8'h80, 8'h3c};
    wire [47:0] oe = {pb, pa, p5, p3, p2, p1};
    gpio_dir_regs i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce),
        .addr_i(q.addr), .wdata_i(q.wdata), .wr_i(q.wr), .rd_i(q.rd),
        .pin_levels_bank4_pins_i(pin_levels_bank4_pins_i), .rdata_o(d), .port1_oe_o(p1),
        .port2_oe_o(p2), .port3_oe_o(p3), .port5_oe_o(p5),
        .porta_oe_o(pa), .portb_oe_o(pb));
    task automatic chk(input string n, input logic [47:0] s, e);
        comparisons++;
        if (s !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_i);
        q <= '{a, v, 1'b1, 1'b0};
        @(posedge clk_i);
        q <= '0;
    endtask
    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [3:0] a);
        @(posedge clk_i);
        q <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_i);
        q <= '0;
        #1;
    endtask
    task automatic wrap_up;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 2000) begin
            errors++;
            wrap_up;
        end
    end
    initial begin
        // Falling from one gives the flops a reset edge at time zero.
        resetn_i <= 1'b0;
        repeat (12) @(posedge clk_i);
        resetn_i <= 1'b1;
        #1 chk("oe after reset", oe, '0);
        foreach (offs[i]) wr(offs[i], vals[i]);
        foreach (offs[i]) ex[i*8 +: 8] = vals[i];
        @(posedge clk_i);
        #1 chk("oe after writes", oe, ex);
        foreach (offs[i]) begin
            rd(offs[i]);
            chk("dir readback", d, WO_READ_VAL);
        end
        wr(4'h3, 8'h00);
        wr(4'h9, 8'h00);
        repeat (2) @(posedge clk_i);
        #1 chk("oe after ignored writes", oe, ex);
        rd(4'hf);
        chk("unmapped read", d, RD_NONE);
        for (int k = 5; k <= 10; k += 5) begin
            @(posedge clk_i);
            pin_levels_bank4_pins_i <= 4'(k);
            repeat (3) @(posedge clk_i);
            rd(4'h3);
            chk("pin levels", d, 48'(k));
        end
        @(posedge clk_i);
        ce <= 1'b0;
        wr(OFF_PORT1_DIR, 8'h00);
        repeat (2) @(posedge clk_i);
        #1 chk("oe while frozen", oe, ex);
        @(posedge clk_i);
        ce <= 1'b1;
        resetn_i <= 1'b0;
        @(posedge clk_i);
        #1 chk("oe in reset", oe, '0);
        @(posedge clk_i);
        resetn_i <= 1'b1;
        wr(OFF_PORTB_DIR, 8'h96);
        repeat (2) @(posedge clk_i);
        #1 chk("oe rerun", oe, 48'h9600_0000_0000);
        wrap_up;
    end
endmodule
bind gpio_dir_regs gpio_dir_regs_properties i_chk (.*);

// File: gpio_dir_regs_properties.sv
// Checker for the port direction block, seen from its ports.
`timescale 1ns/10ps
module gpio_dir_regs_properties import gpio_dir_pkg::*; (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [3:0] pin_levels_bank4_pins_i,
    input wire logic [7:0] rdata_o,
    input wire logic [7:0] port1_oe_o,
    input wire logic [7:0] port2_oe_o,
    input wire logic [7:0] port3_oe_o,
    input wire logic [7:0] port5_oe_o,
    input wire logic [7:0] porta_oe_o,
    input wire logic [7:0] portb_oe_o
);
    wire [47:0] oe = {portb_oe_o, porta_oe_o, port5_oe_o, port3_oe_o,
        port2_oe_o, port1_oe_o};
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // A frozen clock enable delays the output enables, so both edges need it.
    property p_wr; ce_i && wr_i && addr_i == OFF_PORT1_DIR ##1 ce_i
        |=> port1_oe_o == $past(wdata_i, 2); endproperty
    property p_wo; ce_i && rd_i && addr_i != OFF_PIN_LEVELS4
        |=> rdata_o == WO_READ_VAL; endproperty
    property p_pin; (ce_i && $stable(pin_levels_bank4_pins_i))[*4] ##0
        rd_i && addr_i == OFF_PIN_LEVELS4
        |=> rdata_o[3:0] == $past(pin_levels_bank4_pins_i); endproperty
    property p_rsv; rdata_o[7:4] == PIN4_RSVD_VAL; endproperty
    // Reset is async, so this one must not be masked by it.
    property p_rst; disable iff (1'b0) !resetn_i |-> oe == '0; endproperty
    // Only the edge that a direction write would reach is looked at, so a
    // direction write just before does not trip this.
    property p_ro; ce_i && wr_i && addr_i == OFF_PIN_LEVELS4
        |-> ##2 $stable(oe); endproperty
    property p_own; $changed(port1_oe_o)
        |-> $past(wr_i, 2) && $past(addr_i, 2) == 4'h0; endproperty
    a_wr: assert property (p_wr) else $error("bad dir");
    a_wo: assert property (p_wo) else $error("bad wo");
    a_pin: assert property (p_pin) else $error("bad pin");
    a_rsv: assert property (p_rsv) else $error("bad rsv");
    a_rst: assert property (p_rst) else $error("bad rst");
    a_ro: assert property (p_ro) else $error("bad ro");
    a_own: assert property (p_own) else $error("bad oe");
    c_wr: cover property (wr_i && addr_i == OFF_PORTB_DIR);
    c_pin: cover property (rd_i && addr_i == OFF_PIN_LEVELS4);
    c_ro: cover property (wr_i && addr_i == OFF_PIN_LEVELS4);
endmodule
